// [src/cfm_pkg.sv]
package cfm_pkg;
    // ----------------------------------------------------------------
    // Register layout
    // ----------------------------------------------------------------
    localparam logic [7:0] CFM_PTC_RST = 8'h08;
    localparam logic [7:0] CFM_CLR_RST = 8'h1b;
    localparam logic [7:0] CFM_PTC_IMPL_MASK = 8'h3f;
    localparam int CFM_PTC_PGH_BIT = 5;
    localparam int CFM_PTC_PGL_BIT = 4;
    localparam int CFM_CLR_TCE_BIT = 4;
    localparam logic [3:0] CFM_CL_MAX = 4'hb;
    // Status bit positions, active low
    localparam int CFM_ST_OV_BIT = 0;
    localparam int CFM_ST_OC_BIT = 1;
    localparam int CFM_ST_PG_BIT = 2;
    localparam int CFM_ST_TW_BIT = 3;
    // ----------------------------------------------------------------
    // Thresholds, percent of setpoint and tenths of a degree
    // ----------------------------------------------------------------
    localparam logic [7:0] CFM_PGH_LO_PCT = 8'h69;
    localparam logic [7:0] CFM_PGH_HI_PCT = 8'h6e;
    localparam logic [7:0] CFM_PGL_LO_PCT = 8'h5a;
    localparam logic [7:0] CFM_PGL_HI_PCT = 8'h5f;
    localparam logic [7:0] CFM_OV_110_PCT = 8'h6e;
    localparam logic [7:0] CFM_OV_120_PCT = 8'h78;
    localparam logic [7:0] CFM_OV_130_PCT = 8'h82;
    localparam logic [7:0] CFM_CL_BASE_PCT = 8'h25;
    localparam logic [7:0] CFM_CL_STEP_PCT = 8'h0a;
    localparam logic [11:0] CFM_TW_SET_DC = 12'h4b0;
    localparam logic [11:0] CFM_TW_CLR_DC = 12'h492;
    localparam logic [11:0] CFM_ROOM_DC = 12'h0fa;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CFM_CLK_MHZ = 100;
    localparam int CFM_MS_CYCLES = CFM_CLK_MHZ * 1000;
    localparam int CFM_PG_DLY_MAX_MS = 150;

    typedef enum logic [1:0] {
        CFM_PG_OFF = 2'b00,
        CFM_PG_WAIT = 2'b01,
        CFM_PG_WATCH = 2'b11
    } cfm_pg_state_t;

    typedef struct packed {
        logic hs_on;
        logic ls_on;
        logic fault_off;
    } cfm_sw_t;
endpackage : cfm_pkg

// [src/cfm_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module cfm_monitor
    import cfm_pkg::*;
#(
    parameter int PG_DELAY_UNIT_CYCLES = CFM_MS_CYCLES,
    parameter int TC_PCT_PER_DEG = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ptc_wr,
    input wire logic [7:0] ptc_wdata,
    input wire logic clr_wr,
    input wire logic [7:0] clr_wdata,
    input wire logic pwm_active,
    input wire logic [7:0] pg_delay_ms,
    input wire logic pg_off_at_ramp,
    input wire logic [2:0] fall_rate_sel,
    input wire logic [2:0] rise_rate_sel,
    input wire logic [15:0] vout_target,
    input wire logic [15:0] vout_meas,
    input wire logic [15:0] vout_prebias,
    input wire logic [15:0] iout_meas,
    input wire logic [15:0] iout_full,
    input wire logic [11:0] temp_dc,
    input wire logic steady_state,
    input wire logic turn_off_cmd,
    input wire logic ramp_down,
    input wire logic fault_ext,
    input wire logic power_good_in,
    output logic [7:0] ptc_rdata,
    output logic [7:0] clr_rdata,
    output logic [3:0] status_register,
    output logic power_good_oe,
    output logic power_good_out,
    output logic hs_on,
    output logic ls_on,
    output logic conv_off,
    output logic [2:0] fall_rate_q,
    output logic [2:0] rise_rate_q
);
    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [7:0] ptc_q;
    logic [7:0] clr_q;
    logic [3:0] cl_in;
    assign cl_in = (clr_wdata[3:0] > CFM_CL_MAX) ? CFM_CL_MAX : clr_wdata[3:0];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ptc_q <= CFM_PTC_RST;
        end else if (ptc_wr && !pwm_active) begin
            ptc_q <= ptc_wdata & CFM_PTC_IMPL_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clr_q <= CFM_CLR_RST;
        end else if (clr_wr) begin
            clr_q <= {clr_wdata[7:4], cl_in};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ptc_rdata <= CFM_PTC_RST;
            clr_rdata <= CFM_CLR_RST;
        end else begin
            ptc_rdata <= ptc_q & CFM_PTC_IMPL_MASK;
            clr_rdata <= clr_q;
        end
    end

    // Ramp rates held separately for rise and fall
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fall_rate_q <= 3'h0;
            rise_rate_q <= 3'h0;
        end else begin
            fall_rate_q <= fall_rate_sel;
            rise_rate_q <= rise_rate_sel;
        end
    end

    // ----------------------------------------------------------------
    // Thresholds from setpoint
    // ----------------------------------------------------------------
    logic [7:0] pgh_pct;
    logic [7:0] pgl_pct;
    logic [7:0] ov_pct;
    logic [23:0] vm_x100;
    logic [23:0] pgh_lvl;
    logic [23:0] pgl_lvl;
    logic [23:0] ov_lvl;
    logic in_window;
    logic ov_hit;

    assign pgh_pct = ptc_q[CFM_PTC_PGH_BIT] ? CFM_PGH_LO_PCT : CFM_PGH_HI_PCT;
    assign pgl_pct = ptc_q[CFM_PTC_PGL_BIT] ? CFM_PGL_HI_PCT : CFM_PGL_LO_PCT;
    always_comb begin
        case (ptc_q[3:2])
            2'b00: ov_pct = CFM_OV_110_PCT;
            2'b01: ov_pct = CFM_OV_120_PCT;
            default: ov_pct = CFM_OV_130_PCT;
        endcase
    end
    assign vm_x100 = 24'(vout_meas) * 24'd100;
    assign pgh_lvl = 24'(vout_target) * 24'(pgh_pct);
    assign pgl_lvl = 24'(vout_target) * 24'(pgl_pct);
    assign ov_lvl = 24'(vout_target) * 24'(ov_pct);
    assign in_window = (vm_x100 <= pgh_lvl) && (vm_x100 >= pgl_lvl);
    assign ov_hit = (vout_meas > vout_prebias) && (vm_x100 > ov_lvl);

    // ----------------------------------------------------------------
    // Thermal warning with hysteresis
    // ----------------------------------------------------------------
    logic tw_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tw_q <= 1'b0;
        end else if (temp_dc > CFM_TW_SET_DC) begin
            tw_q <= 1'b1;
        end else if (temp_dc < CFM_TW_CLR_DC) begin
            tw_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Power-good supervision
    // ----------------------------------------------------------------
    cfm_pg_state_t pg_q;
    logic [31:0] dly_cnt_q;
    logic [7:0] dly_ms_q;
    logic pg_warn;
    logic pg_drive_low;
    logic off_low_now;
    logic oc_q;
    logic ov_q;
    logic fault_q;

    assign off_low_now = pg_off_at_ramp ? ramp_down : turn_off_cmd;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pg_q <= CFM_PG_OFF;
            dly_cnt_q <= 32'h0;
            dly_ms_q <= 8'h0;
        end else begin
            case (pg_q)
                CFM_PG_OFF: begin
                    dly_cnt_q <= 32'h0;
                    dly_ms_q <= 8'h0;
                    if (steady_state && !off_low_now) begin
                        pg_q <= CFM_PG_WAIT;
                    end
                end
                CFM_PG_WAIT: begin
                    if (off_low_now || !steady_state) begin
                        pg_q <= CFM_PG_OFF;
                    end else if (dly_ms_q >= pg_delay_ms || dly_ms_q >= 8'(CFM_PG_DLY_MAX_MS)) begin
                        pg_q <= CFM_PG_WATCH;
                    end else if (dly_cnt_q == 32'(PG_DELAY_UNIT_CYCLES - 1)) begin
                        dly_cnt_q <= 32'h0;
                        dly_ms_q <= dly_ms_q + 8'h1;
                    end else begin
                        dly_cnt_q <= dly_cnt_q + 32'h1;
                    end
                end
                CFM_PG_WATCH: begin
                    if (off_low_now || fault_q) begin
                        pg_q <= CFM_PG_OFF;
                    end
                end
                default: pg_q <= CFM_PG_OFF;
            endcase
        end
    end

    assign pg_warn = (pg_q == CFM_PG_WATCH) && (!in_window || !power_good_in);
    assign pg_drive_low = (pg_q != CFM_PG_WATCH) || !in_window || off_low_now;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            power_good_oe <= 1'b1;
            power_good_out <= 1'b0;
        end else begin
            power_good_oe <= pg_drive_low;
            power_good_out <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Overcurrent limit with temperature compensation
    // ----------------------------------------------------------------
    logic [7:0] cl_pct;
    logic [15:0] tc_add_pct;
    logic [31:0] oc_lvl;
    logic [31:0] io_x100;
    logic oc_hit;
    logic [11:0] dt_dc;

    assign cl_pct = 8'(CFM_CL_BASE_PCT + CFM_CL_STEP_PCT * 8'(clr_q[3:0]));
    assign dt_dc = (temp_dc > CFM_ROOM_DC) ? (temp_dc - CFM_ROOM_DC) : 12'h0;
    assign tc_add_pct = clr_q[CFM_CLR_TCE_BIT]
        ? 16'((32'(dt_dc) * 32'(TC_PCT_PER_DEG)) / 32'd1000) : 16'h0;
    assign oc_lvl = 32'(iout_full) * (32'(cl_pct) + 32'(tc_add_pct));
    assign io_x100 = 32'(iout_meas) * 32'd100;
    assign oc_hit = (vout_meas > vout_prebias) && (io_x100 >= oc_lvl);

    // ----------------------------------------------------------------
    // Faults, switches and status
    // ----------------------------------------------------------------
    assign fault_q = oc_q || ov_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oc_q <= 1'b0;
            ov_q <= 1'b0;
        end else begin
            if (oc_hit) begin
                oc_q <= 1'b1;
            end else if (turn_off_cmd) begin
                oc_q <= 1'b0;
            end
            if (ov_hit) begin
                ov_q <= 1'b1;
            end else if (turn_off_cmd) begin
                ov_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hs_on <= 1'b0;
            ls_on <= 1'b0;
            conv_off <= 1'b1;
        end else if (ov_hit || ov_q) begin
            hs_on <= 1'b0;
            ls_on <= 1'b1;
            conv_off <= 1'b1;
        end else if (oc_hit || oc_q || fault_ext) begin
            hs_on <= 1'b0;
            ls_on <= 1'b0;
            conv_off <= 1'b1;
        end else begin
            hs_on <= pwm_active;
            ls_on <= pwm_active;
            conv_off <= turn_off_cmd;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_register <= 4'hf;
        end else begin
            status_register[CFM_ST_OV_BIT] <= !(ov_q || ov_hit);
            status_register[CFM_ST_OC_BIT] <= !(oc_q || oc_hit);
            status_register[CFM_ST_PG_BIT] <= !pg_warn;
            status_register[CFM_ST_TW_BIT] <= !tw_q;
        end
    end
endmodule : cfm_monitor
`default_nettype wire

// [verif/cfm_monitor_props.sv]
`timescale 1ns/1ps
`default_nettype none
// --------
// Port checker
// --------
module cfm_monitor_props
    import cfm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ptc_wr,
    input wire logic [7:0] ptc_wdata,
    input wire logic clr_wr,
    input wire logic [7:0] clr_wdata,
    input wire logic pwm_active,
    input wire logic [11:0] temp_dc,
    input wire logic turn_off_cmd,
    input wire logic fault_ext,
    input wire logic pg_off_at_ramp,
    input wire logic [7:0] ptc_rdata,
    input wire logic [7:0] clr_rdata,
    input wire logic [3:0] status_register,
    input wire logic power_good_oe,
    input wire logic power_good_out,
    input wire logic hs_on,
    input wire logic ls_on,
    input wire logic conv_off
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_ptc_wr; ptc_wr && !pwm_active |-> ##2 ptc_rdata == ($past(ptc_wdata, 2) & CFM_PTC_IMPL_MASK); endproperty
    a_ptc_wr: assert property (p_ptc_wr) else $error("ptc write lost");
    property p_ptc_ref; ptc_wr && pwm_active ##1 !(ptc_wr && !pwm_active) |=> $stable(ptc_rdata); endproperty
    a_ptc_ref: assert property (p_ptc_ref) else $error("ptc write not refused");
    property p_clamp; clr_wr && (clr_wdata[3:0] > CFM_CL_MAX) |-> ##2 clr_rdata[3:0] == CFM_CL_MAX; endproperty
    a_clamp: assert property (p_clamp) else $error("limit not clamped");
    property p_tw_set; temp_dc > CFM_TW_SET_DC |-> ##2 !status_register[CFM_ST_TW_BIT]; endproperty
    a_tw_set: assert property (p_tw_set) else $error("thermal flag missing");
    property p_oc_off; !status_register[CFM_ST_OC_BIT] |-> !hs_on && !ls_on; endproperty
    a_oc_off: assert property (p_oc_off) else $error("switch on in overcurrent");
    property p_ov_sw; !status_register[CFM_ST_OV_BIT] && status_register[CFM_ST_OC_BIT] |-> !hs_on && ls_on; endproperty
    a_ov_sw: assert property (p_ov_sw) else $error("bad overvoltage switches");
    property p_ext; fault_ext |=> conv_off && !hs_on && !ls_on; endproperty
    a_ext: assert property (p_ext) else $error("fault left output on");
    property p_pg_cmd; turn_off_cmd && !pg_off_at_ramp |=> power_good_oe; endproperty
    a_pg_cmd: assert property (p_pg_cmd) else $error("pin not pulled at turn-off");
    property p_pg_od; power_good_out == 1'b0; endproperty
    a_pg_od: assert property (p_pg_od) else $error("pin driven high");
endmodule : cfm_monitor_props
bind cfm_monitor cfm_monitor_props u_props(.clk, .rst_n, .ptc_wr, .ptc_wdata, .clr_wr, .clr_wdata, .pwm_active,
    .temp_dc, .turn_off_cmd, .fault_ext, .pg_off_at_ramp, .ptc_rdata, .clr_rdata, .status_register,
    .power_good_oe, .power_good_out, .hs_on, .ls_on, .conv_off);
`default_nettype wire

// [verif/cfm_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// --------
// Host side: config writes, status polling
// --------
module cfm_host_model (
    input wire logic clk,
    output logic ptc_wr,
    output logic [7:0] ptc_wdata,
    output logic clr_wr,
    output logic [7:0] clr_wdata,
    input wire logic [7:0] clr_rdata,
    input wire logic [3:0] status_register,
    output logic [3:0] status_seen
);
    initial {ptc_wr, clr_wr, ptc_wdata, clr_wdata} = '0;
    always @(posedge clk) status_seen <= status_register;
    task automatic wr(input logic to_clr, input logic [7:0] d);
        @(negedge clk);
        {ptc_wr, clr_wr} = {!to_clr, to_clr};
        {ptc_wdata, clr_wdata} = {d, d};
        @(negedge clk);
        {ptc_wr, clr_wr} = 2'b00;
        {ptc_wdata, clr_wdata} = {~d, ~d};
    endtask : wr
    task automatic set_cl(input logic [3:0] cl);
        wr(1'b1, {clr_rdata[7:5], 1'b1, cl});
    endtask : set_cl
endmodule : cfm_host_model
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// --------
// Testbench
// --------
module tb_top;
    import cfm_pkg::*;
    logic clk, rst_n, ptc_wr, clr_wr, pwm_active, pg_off_at_ramp, steady_state, turn_off_cmd, ramp_down, fault_ext;
    logic ext_low, power_good_in, power_good_oe, power_good_out, hs_on, ls_on, conv_off, off0;
    logic [7:0] ptc_wdata, clr_wdata, ptc_rdata, clr_rdata, pg_delay_ms, old;
    logic [2:0] fall_rate_sel, rise_rate_sel, fall_rate_q, rise_rate_q;
    logic [15:0] vout_target, vout_meas, vout_prebias, iout_meas, iout_full;
    logic [11:0] temp_dc;
    logic [3:0] status_register, status_seen;
    logic [31:0] seed;
    logic [15:0] tgt [6] = '{16'd1000, 16'd1000, 16'd1000, 16'd1000, 16'd1100, 16'd1200};
    logic [15:0] mv [6] = '{16'd1040, 16'd1060, 16'd960, 16'd940, 16'd1060, 16'd1060};
    logic [15:0] mv2 [4] = '{16'd1080, 16'd920, 16'd1120, 16'd880};
    int miscompares, checked;
    assign power_good_in = !(power_good_oe || ext_low);
    cfm_monitor #(.PG_DELAY_UNIT_CYCLES(10)) u_dut(.clk, .rst_n, .ptc_wr, .ptc_wdata, .clr_wr, .clr_wdata,
        .pwm_active, .pg_delay_ms, .pg_off_at_ramp, .fall_rate_sel, .rise_rate_sel, .vout_target, .vout_meas,
        .vout_prebias, .iout_meas, .iout_full, .temp_dc, .steady_state, .turn_off_cmd, .ramp_down, .fault_ext,
        .power_good_in, .ptc_rdata, .clr_rdata, .status_register, .power_good_oe, .power_good_out, .hs_on,
        .ls_on, .conv_off, .fall_rate_q, .rise_rate_q);
    cfm_host_model u_host(.clk, .ptc_wr, .ptc_wdata, .clr_wr, .clr_wdata, .clr_rdata, .status_register,
        .status_seen);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [7:0] clamp_cl(input logic [7:0] d);
        return {d[7:4], (d[3:0] > CFM_CL_MAX) ? CFM_CL_MAX : d[3:0]};
    endfunction : clamp_cl
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic print_verdict;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        print_verdict;
    end
    initial begin
        {rst_n, pwm_active, pg_off_at_ramp, steady_state, turn_off_cmd, ramp_down, fault_ext, ext_low} = '0;
        {pg_delay_ms, fall_rate_sel, rise_rate_sel, temp_dc, vout_target, vout_meas} = '0;
        {vout_prebias, iout_meas, iout_full} = {16'd0, 16'd0, 16'd100};
        {miscompares, checked} = '0;
        seed = 32'h4063;
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        check(16'({ptc_rdata, clr_rdata}), {CFM_PTC_RST, CFM_CLR_RST});
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            {rise_rate_sel, fall_rate_sel} = seed[21:16];
            u_host.wr(1'b0, seed[7:0]);
            u_host.wr(1'b1, seed[15:8]);
            cyc(2);
            check(16'(ptc_rdata), {10'h000, seed[5:0]});
            check(16'(clr_rdata), 16'(clamp_cl(seed[15:8])));
            check(16'({rise_rate_q, fall_rate_q}), 16'(seed[21:16]));
        end
        u_host.wr(1'b0, 8'h38);
        cyc(2);
        pwm_active = 1'b1;
        u_host.wr(1'b0, 8'h05);
        cyc(2);
        check(16'(ptc_rdata), 16'h0038);
        old = clr_rdata;
        u_host.set_cl(4'h5);
        cyc(2);
        check(16'(clr_rdata), {8'h00, old[7:5], 5'h15});
        off0 = conv_off;
        temp_dc = 12'd1201;
        cyc(2);
        check(16'({status_register[CFM_ST_TW_BIT], conv_off}), 16'(off0));
        temp_dc = 12'd1180;
        cyc(2);
        check(16'(status_register[CFM_ST_TW_BIT]), 16'h0);
        check(16'(status_seen[CFM_ST_TW_BIT]), 16'h0);
        temp_dc = 12'd1169;
        cyc(2);
        check(16'(status_register[CFM_ST_TW_BIT]), 16'h1);
        {vout_target, vout_meas, pg_delay_ms, steady_state} = {16'd1000, 16'd1000, 8'd3, 1'b1};
        cyc(25);
        check(16'(power_good_oe), 16'h1);
        cyc(10);
        check(16'(power_good_oe), 16'h0);
        for (int i = 0; i < 6; i++) begin
            {vout_target, vout_meas} = {tgt[i], mv[i]};
            cyc(3);
            check(16'({power_good_oe, status_register[CFM_ST_PG_BIT]}), 16'(1 + i % 2));
        end
        check(16'(power_good_out), 16'h0);
        {vout_target, pwm_active} = {16'd1000, 1'b0};
        u_host.wr(1'b0, 8'h08);
        for (int i = 0; i < 4; i++) begin
            vout_meas = mv2[i];
            cyc(3);
            check(16'({power_good_oe, status_register[CFM_ST_PG_BIT]}), 16'(1 + i / 2));
        end
        {vout_meas, pwm_active} = {16'd1000, 1'b1};
        cyc(3);
        ext_low = 1'b1;
        cyc(2);
        check(16'(status_register[CFM_ST_PG_BIT]), 16'h0);
        ext_low = 1'b0;
        cyc(3);
        check(16'({power_good_oe, status_register[CFM_ST_PG_BIT]}), 16'h1);
        turn_off_cmd = 1'b1;
        cyc(1);
        turn_off_cmd = 1'b0;
        check(16'(power_good_oe), 16'h1);
        pg_off_at_ramp = 1'b1;
        cyc(40);
        check(16'(power_good_oe), 16'h0);
        turn_off_cmd = 1'b1;
        cyc(2);
        check(16'(power_good_oe), 16'h0);
        ramp_down = 1'b1;
        cyc(1);
        check(16'(power_good_oe), 16'h1);
        {turn_off_cmd, ramp_down, pg_off_at_ramp} = 3'b000;
        vout_meas = 16'd1400;
        cyc(2);
        check(16'({status_register[CFM_ST_OV_BIT], hs_on, ls_on}), 16'h1);
        {vout_meas, turn_off_cmd} = {16'd1000, 1'b1};
        cyc(1);
        turn_off_cmd = 1'b0;
        cyc(1);
        check(16'(power_good_oe), 16'h1);
        check(16'(status_register[CFM_ST_OV_BIT]), 16'h1);
        {iout_full, iout_meas, vout_prebias} = {16'd100, 16'd200, 16'd2000};
        cyc(3);
        check(16'(status_register[CFM_ST_OC_BIT]), 16'h1);
        {iout_meas, vout_prebias} = {16'd89, 16'd0};
        cyc(3);
        check(16'(status_register[CFM_ST_OC_BIT]), 16'h1);
        iout_meas = 16'd200;
        cyc(2);
        check(16'({status_register[CFM_ST_OC_BIT], hs_on, ls_on, conv_off}), 16'h1);
        {iout_meas, turn_off_cmd} = {16'd0, 1'b1};
        cyc(1);
        {turn_off_cmd, fault_ext} = 2'b01;
        cyc(2);
        check(16'({hs_on, ls_on, conv_off}), 16'h1);
        fault_ext = 1'b0;
        cyc(2);
        print_verdict;
    end
endmodule : tb_top
`default_nettype wire
